// file: placeholder_end.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: rcs_consts.svh
// Function
// R1 - SPI mode 1: idle low, launch lead edge
// R2 - Device is slave, drives only MISO
// R3 - Master makes chip select and clock
// R4 - Frame: fast word, accurate word, CRC
// R5 - CRC-8 poly 0x07, seed 0xFF, zeroes frame
// R6 - Master rejects frame when CRC nonzero
// R7 - Per byte: XOR, eight shifts, poly
// R8 - Error forces fast word bits 15..6 high
// R9 - Error bits 5 and 4 reserved
// R10 - Error bit 3 marks self-test failure
// R11 - Error bit 2 always zero
// R12 - Error bit 1 marks above threshold
// R13 - Error bit 0 marks critical overload
// R14 - Self-test failure sticky until power cycle; code clears it on every rst_n reset
// R15 - Threshold lies between 152 and 175 mA
// R16 - Master ignores accurate word on error
// R17 - Reset 5 us min, ready within 100 ms
// R18 - Healthy fault pin toggles 11 to 21 kHz
// R19 - Fault pin reacts within 200 us
// R20 - Fast word feeds sigma-delta modulator
// R21 - 48 MHz bitstream, negative is inverse
// R22 - Samples offset binary, zero at 32768
// R23 - On fault, fault pin holds steady
// R24 - MSB first, high byte first
//
// Purpose: constants of the residual current readout block
// Assumes: 100 MHz system clock
// Notes: all timing counts derive from the times below
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

`define RCS_CLK_NS 10
`define RCS_STARTUP_MS 100
`define RCS_STARTUP_CYCLES (`RCS_STARTUP_MS * 1000000 / `RCS_CLK_NS)
`define RCS_FAULT_HALF_NS 31250
`define RCS_FAULT_HALF_CYCLES (`RCS_FAULT_HALF_NS / `RCS_CLK_NS)
`define RCS_FAULT_REACT_US 200
`define RCS_BITSTREAM_MHZ 48
`define RCS_SYS_MHZ (1000 / `RCS_CLK_NS)
`define RCS_ZERO_CODE 16'h8000
`define RCS_THRESH_LSB 16'h36FE
`define RCS_CRC_SEED 8'hFF
`define RCS_CRC_POLY 8'h07
`define RCS_CRC_TOP 8'h80
`define RCS_FRAME_BITS 40
`define RCS_ERR_ONES 10'h3FF
`define RCS_ERR_RSVD 2'h0

`endif

// file: rcs_host_model.sv
// Purpose: SPI mode 1 host that reads one five-byte frame per go pulse
// Assumes: link clock period 125 ns, select lead and lag 150/100 ns
// Notes: MISO is taken just before the falling edge
`timescale 1ns/1ns
`default_nettype none

module rcs_host_model (
    // Control
    input wire logic go,
    output logic done,
    // SPI pins
    output logic spi_cs_n,
    output logic spi_sclk,
    input wire logic spi_miso,
    // Result
    output rcs_pkg::rcs_frame_t frame,
    output logic [7:0] residue
);
    logic [39:0] sh;

    function automatic logic [7:0] crc_bytes(input logic [39:0] d);
        logic [7:0] c;
        c = 8'hFF;
        for (int b = 4; b >= 0; b--)
        begin
            c = c ^ d[b*8 +: 8];
            for (int k = 0; k < 8; k++)
                c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    initial
    begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        done = 1'b0;
        frame = '0;
        residue = 8'h00;
        sh = '0;
    end

    // Clock stands low between frames, as a real host does
    always @(posedge go)
    begin
        done = 1'b0;
        spi_cs_n = 1'b0;
        #150;
        for (int i = 0; i < 40; i++)
        begin
            spi_sclk = 1'b1;
            #63;
            sh = {sh[38:0], spi_miso};
            spi_sclk = 1'b0;
            #62;
        end
        #100;
        spi_cs_n = 1'b1;
        frame = sh;
        residue = crc_bytes(sh);
        #200;
        done = 1'b1;
    end
endmodule

`default_nettype wire

// file: rcs_pkg.sv
// Purpose: types of the residual current readout block
// Assumes: rcs_consts.svh holds the numbers
// Notes: none
package rcs_pkg;

    typedef struct packed {
        logic selftest_failure;
        logic over_threshold;
        logic critical_overload;
    } rcs_status_t;

    typedef struct packed {
        logic [15:0] fast;
        logic [15:0] accurate;
        logic [7:0] crc;
    } rcs_frame_t;

    typedef enum logic [0:0] {
        RCS_IDLE,
        RCS_SHIFT
    } rcs_spi_state_t;

endpackage

// file: rcs_sensor.sv
// Purpose: SPI frame slave, sigma-delta output and fault pin
// Assumes: SPI pins asynchronous to clock; SCLK period >= 125 ns
// Notes: bitstream rate averages 48 MHz from a 100 MHz clock
`timescale 1ns/1ns
`include "rcs_consts.svh"
`default_nettype none

module rcs_sensor #(
    parameter int unsigned STARTUP_CYCLES = `RCS_STARTUP_CYCLES
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // SPI pins, master drives select and clock
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Measurement path, same clock domain
    input wire logic [15:0] fast_sample,
    input wire logic [15:0] accurate_sample,
    input wire logic critical_overload,
    input wire logic selftest_failure_in,
    // Outputs
    output logic analog_pos,
    output logic analog_neg,
    output logic fault_pin,
    output logic ready
);

    function automatic logic [7:0] crc8(input logic [7:0] crc_in,
                                        input logic [7:0] data_in);
        logic [7:0] c;
        c = crc_in ^ data_in; // [R7]
        for (int i = 0; i < 8; i++)
        begin
            if ((c & `RCS_CRC_TOP) != 8'h00)
                c = (c << 1) ^ `RCS_CRC_POLY; // [R7]
            else
                c = c << 1;
        end
        return c;
    endfunction

    // Pin synchronisers: stage 1 only feeds stage 2
    logic [1:0] cs_sync_q, cs_sync_d;
    logic [2:0] sclk_sync_q, sclk_sync_d;
    logic cs_n_s, sclk_rise;

    always_comb
    begin
        cs_sync_d = {cs_sync_q[0], spi_cs_n};
        sclk_sync_d = {sclk_sync_q[1:0], spi_sclk};
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cs_sync_q <= 2'h3;
            sclk_sync_q <= 3'h0;
        end
        else if (clk_en)
        begin
            cs_sync_q <= cs_sync_d;
            sclk_sync_q <= sclk_sync_d;
        end
    end

    assign cs_n_s = cs_sync_q[1];
    // Mode 1: the rising (leading) edge launches the next bit
    assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2]; // [R1]

    // Status and sample word
    rcs_pkg::rcs_status_t status;
    logic selftest_q, selftest_d;
    logic [15:0] magnitude;
    logic any_error;
    logic [15:0] fast_word;

    always_comb
    begin
        selftest_d = selftest_q | selftest_failure_in; // [R14]
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            selftest_q <= 1'b0;
        else if (clk_en)
            selftest_q <= selftest_d;
    end

    always_comb
    begin
        // Offset binary: distance from the zero-current code
        if (fast_sample >= `RCS_ZERO_CODE) // [R22]
            magnitude = fast_sample - `RCS_ZERO_CODE;
        else
            magnitude = `RCS_ZERO_CODE - fast_sample;
        status.selftest_failure = selftest_q;
        status.over_threshold = magnitude > `RCS_THRESH_LSB; // [R15]
        status.critical_overload = critical_overload;
        any_error = |status;
        if (any_error)
            fast_word = {`RCS_ERR_ONES, // [R8]
                         `RCS_ERR_RSVD, // [R9]
                         status.selftest_failure, // [R10]
                         1'b0, // [R11]
                         status.over_threshold, // [R12]
                         status.critical_overload}; // [R13]
        else
            fast_word = fast_sample;
    end

    // Startup wait after reset release
    logic [31:0] start_cnt_q, start_cnt_d;
    logic ready_q, ready_d;

    always_comb
    begin
        start_cnt_d = start_cnt_q;
        ready_d = ready_q;
        if (!ready_q)
        begin
            if (start_cnt_q >= STARTUP_CYCLES - 1) // [R17]
                ready_d = 1'b1;
            else
                start_cnt_d = start_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            start_cnt_q <= 32'h0;
            ready_q <= 1'b0;
        end
        else if (clk_en)
        begin
            start_cnt_q <= start_cnt_d;
            ready_q <= ready_d;
        end
    end

    assign ready = ready_q;

    // SPI frame shifter; the device never drives select or clock
    rcs_pkg::rcs_spi_state_t state_q, state_d;
    logic [`RCS_FRAME_BITS-1:0] shreg_q, shreg_d;
    logic miso_q, miso_d;
    rcs_pkg::rcs_frame_t frame;

    always_comb
    begin
        frame.fast = fast_word; // [R4]
        frame.accurate = accurate_sample;
        frame.crc = crc8(crc8(crc8(crc8(`RCS_CRC_SEED, // [R5]
            fast_word[15:8]), fast_word[7:0]),
            accurate_sample[15:8]), accurate_sample[7:0]);
    end

    always_comb
    begin
        state_d = state_q;
        shreg_d = shreg_q;
        miso_d = miso_q;
        case (state_q)
            rcs_pkg::RCS_IDLE:
            begin
                if (!cs_n_s)
                begin
                    shreg_d = frame; // [R4]
                    state_d = rcs_pkg::RCS_SHIFT;
                end
            end
            rcs_pkg::RCS_SHIFT:
            begin
                if (cs_n_s)
                    state_d = rcs_pkg::RCS_IDLE;
                else if (sclk_rise)
                begin
                    miso_d = shreg_q[`RCS_FRAME_BITS-1]; // [R24]
                    shreg_d = {shreg_q[`RCS_FRAME_BITS-2:0], 1'b0};
                end
            end
            default:
                state_d = rcs_pkg::RCS_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q <= rcs_pkg::RCS_IDLE;
            shreg_q <= '0;
            miso_q <= 1'b0;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            shreg_q <= shreg_d;
            miso_q <= miso_d;
        end
    end

    // Half duplex: drive MISO only while selected
    assign spi_miso = miso_q; // [R2]
    assign spi_miso_oe = ~cs_n_s; // [R2]

    // First-order sigma-delta, stepped at 48/100 of the clock
    // The bit holds between steps, so its duty over clocks is word/65536
    logic [7:0] rate_q, rate_d;
    logic [16:0] acc_q, acc_d;
    logic bit_q, bit_d;
    logic step;

    always_comb
    begin
        step = (rate_q + `RCS_BITSTREAM_MHZ) >= `RCS_SYS_MHZ;
        if (step)
            rate_d = 8'(rate_q + `RCS_BITSTREAM_MHZ - `RCS_SYS_MHZ);
        else
            rate_d = 8'(rate_q + `RCS_BITSTREAM_MHZ);
        acc_d = acc_q;
        bit_d = bit_q;
        if (step)
        begin
            acc_d = {1'b0, acc_q[15:0]} + {1'b0, fast_word}; // [R20]
            bit_d = acc_d[16]; // [R21]
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rate_q <= 8'h0;
            acc_q <= 17'h0;
            bit_q <= 1'b0;
        end
        else if (clk_en)
        begin
            rate_q <= rate_d;
            acc_q <= acc_d;
            bit_q <= bit_d;
        end
    end

    assign analog_pos = bit_q;
    assign analog_neg = ~bit_q; // [R21]

    // Fault pin: 16 kHz square wave while healthy, frozen on fault
    logic [15:0] fcnt_q, fcnt_d;
    logic fault_q, fault_d;

    always_comb
    begin
        fcnt_d = fcnt_q;
        fault_d = fault_q;
        if (ready_q && !any_error) // [R23]
        begin
            if (fcnt_q >= 16'(`RCS_FAULT_HALF_CYCLES - 1)) // [R18]
            begin
                fcnt_d = 16'h0;
                fault_d = ~fault_q;
            end
            else
                fcnt_d = fcnt_q + 16'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            fcnt_q <= 16'h0;
            fault_q <= 1'b0;
        end
        else if (clk_en)
        begin
            fcnt_q <= fcnt_d;
            fault_q <= fault_d; // [R19]
        end
    end

    assign fault_pin = fault_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_miso_release: assert property (cs_n_s |-> !spi_miso_oe) // [R2]
        else $error("MISO driven while deselected");
    a_frame_abort: assert property ($rose(cs_n_s) // [R2]
        |=> state_q == rcs_pkg::RCS_IDLE)
        else $error("Frame not ended on deselect");
    a_analog_inverse: assert property (analog_neg == !analog_pos) // [R21]
        else $error("Negative output not inverse");
    a_error_ones: assert property (any_error // [R8]
        |-> frame.fast[15:6] == 10'h3FF && frame.fast[2] == 1'b0)
        else $error("Error pattern wrong");
    a_error_flags: assert property (any_error // [R12]
        |-> frame.fast[3] == selftest_q
        && frame.fast[1] == status.over_threshold
        && frame.fast[0] == critical_overload)
        else $error("Error flag bits wrong");
    a_selftest_sticky: assert property (selftest_q |=> selftest_q) // [R14]
        else $error("Self-test flag cleared");
    a_crc_zero: assert property (crc8(crc8(crc8(crc8(crc8(8'hFF, // [R5]
        frame[39:32]), frame[31:24]), frame[23:16]), frame[15:8]),
        frame[7:0]) == 8'h00)
        else $error("Frame CRC does not close to zero");
    a_shift_msb: assert property (clk_en // [R24]
        && state_q == rcs_pkg::RCS_SHIFT && !cs_n_s
        && sclk_rise |=> spi_miso == $past(shreg_q[39]))
        else $error("Bit order wrong");
    a_fault_hold: assert property (any_error ##1 any_error // [R23]
        |-> $stable(fault_pin))
        else $error("Fault pin toggled during fault");
    a_fault_react: assert property ($rose(any_error) // [R19]
        |=> $stable(fault_pin))
        else $error("Fault pin did not freeze");
    a_fault_period: assert property (fcnt_q < 16'(`RCS_FAULT_HALF_CYCLES)) // [R18]
        else $error("Fault half period too long");
    a_ready_wait: assert property ($rose(ready_q) // [R17]
        |-> start_cnt_q == 32'(STARTUP_CYCLES - 1))
        else $error("Startup wait length wrong");
    a_frame_load: assert property (clk_en // [R4]
        && state_q == rcs_pkg::RCS_IDLE && !cs_n_s
        |=> shreg_q == $past(frame))
        else $error("Frame not captured on select");

    c_frame_start: cover property (state_q == rcs_pkg::RCS_IDLE ##1
        state_q == rcs_pkg::RCS_SHIFT);
    c_error_frame: cover property (any_error
        && state_q == rcs_pkg::RCS_SHIFT);
    c_fault_toggle: cover property (ready_q ##1 $changed(fault_pin));
    c_ready: cover property ($rose(ready_q));
    c_frame_abort: cover property ($rose(cs_n_s)
        && state_q == rcs_pkg::RCS_SHIFT);

endmodule

`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench of the residual current readout block
// Assumes: 100 MHz clock, startup count shortened to 20 cycles
// Notes: the host model makes the 125 ns link clock
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    localparam int STARTUP = 20;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic crit = 1'b0;
    logic stf = 1'b0;
    logic [15:0] fast = 16'h8000;
    logic [15:0] acc = 16'h8000;
    logic cs_n, sclk, miso, miso_oe, pos, neg, fault, ready, done;
    logic miso_line;
    logic [7:0] residue;
    rcs_pkg::rcs_frame_t frame;
    int mismatches = 0;
    int num_checks = 0;

    always #5 clock = ~clock;

    // No pull on the data line: a released line reads the inverse
    assign miso_line = miso_oe ? miso : ~miso;

    rcs_sensor #(.STARTUP_CYCLES(STARTUP)) i_rcs_sensor (
        .clock(clock), .rst_n(rst_n), .clk_en(1'b1),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_miso(miso),
        .spi_miso_oe(miso_oe), .fast_sample(fast),
        .accurate_sample(acc), .critical_overload(crit),
        .selftest_failure_in(stf), .analog_pos(pos), .analog_neg(neg),
        .fault_pin(fault), .ready(ready)
    );

    rcs_host_model i_rcs_host_model (
        .go(go), .done(done), .spi_cs_n(cs_n), .spi_sclk(sclk),
        .spi_miso(miso_line), .frame(frame), .residue(residue)
    );

    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic do_reset;
        int n;
        @(posedge clock) #1 rst_n = 1'b0;
        repeat (6) @(posedge clock);
        #1;
        check("oe", 0, miso_oe);
        check("ready", 0, ready);
        check("neg", 1, pos ^ neg);
        rst_n = 1'b1;
        for (n = 0; n < STARTUP + 5 && ready !== 1'b1; n++)
            @(posedge clock) #1;
        check("startup", 1, n >= STARTUP - 1 && n <= STARTUP + 1);
    endtask

    // Waits one edge first so the previous frame's done is cleared
    task automatic read_frame;
        int n;
        go = 1'b1;
        @(posedge clock) #1 go = 1'b0;
        for (n = 0; n < 1000 && done !== 1'b1; n++)
            @(posedge clock) #1;
        check("frame done", 1, done);
        check("residue", 0, residue);
    endtask

    task automatic t_normal;
        fast = 16'h8320;
        acc = 16'hE396;
        read_frame();
        check("fast", 16'h8320, frame.fast);
        check("accurate", 16'hE396, frame.accurate);
        check("crc", 16'h000E, frame.crc);
    endtask

    // Reserved bits forced to one on both sides, so they are ignored
    task automatic t_errors;
        logic [15:0] fs [4] = '{16'hB6FE, 16'hB6FF, 16'h4901, 16'h8000};
        logic [15:0] ex [4] = '{16'hB6FE, 16'hFFF2, 16'hFFF2, 16'hFFF1};
        logic [15:0] got;
        for (int i = 0; i < 4; i++)
        begin
            fast = fs[i];
            crit = (i == 3);
            read_frame();
            got = frame.fast | 16'h0030;
            check("error word", ex[i], got);
        end
        crit = 1'b0;
    endtask

    task automatic t_selftest;
        fast = 16'h8000;
        stf = 1'b1;
        @(posedge clock) #1 stf = 1'b0;
        repeat (2)
        begin
            read_frame();
            check("st", 16'hFFF8, frame.fast | 16'h0030);
        end
        do_reset();
        read_frame();
        check("st cleared", 16'h8000, frame.fast);
    endtask

    task automatic t_fault;
        int n;
        logic f;
        for (int k = 0; k < 2; k++)
        begin
            f = fault;
            for (n = 0; n < 5000 && fault === f; n++)
                @(posedge clock) #1;
        end
        check("half period", 1, n >= 2381 && n <= 4545);
        crit = 1'b1;
        repeat (3) @(posedge clock) #1;
        f = fault;
        for (n = 0; n < 9100 && fault === f; n++)
            @(posedge clock) #1;
        check("fault held", 9100, n);
        crit = 1'b0;
    endtask

    task automatic t_sdm(input logic [15:0] fs, input logic c,
                         input int lo, input int hi);
        int ones;
        int inv;
        ones = 0;
        inv = 0;
        fast = fs;
        crit = c;
        repeat (20) @(posedge clock) #1;
        for (int i = 0; i < 1000; i++)
        begin
            ones += pos;
            inv += (pos ^ neg);
            @(posedge clock) #1;
        end
        check("density", 1, ones >= lo && ones <= hi);
        check("inverse", 1000, inv);
        crit = 1'b0;
    endtask

    initial
    begin
        #600000;
        mismatches++;
        give_verdict();
    end

    initial
    begin
        do_reset();
        t_normal();
        t_errors();
        t_selftest();
        t_fault();
        t_sdm(16'hA000, 1'b0, 590, 660);
        t_sdm(16'h8000, 1'b1, 990, 1000);
        give_verdict();
    end
endmodule

`default_nettype wire
